/* dv/fcs_clock_ctrl_sva.sv */
// checker: bus handshake and control output relations of the clock block
`timescale 1ns/1ps
module fcs_clock_ctrl_sva
  import fcs_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [3:0]        wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic              wb_ack_o,
  input wire logic              debug_mode_i,
  input wire logic              stop_mode_i,
  input wire fcs_pkg::fcs_ctl_s ctl_o
);
  logic [7:0] s1;
  logic [7:0] s2;
  logic [1:0] sq;
  logic       calm;
  logic       wack;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  assign wack = wb_ack_o && wb_we_i && wb_sel_i[0];
  assign calm = !stop_mode_i && sq == 2'h0;
  // shadows copy at the ack edge, so they line up with the registered outputs
  always_ff @(posedge clk_i) begin
    sq <= {sq[0], stop_mode_i};
    if (rst_i) begin
      s1 <= 8'h04;
      s2 <= 8'h40;
    end else if (wack && wb_adr_i == 4'h0) begin
      s1 <= wb_dat_i[7:0];
    end else if (wack && wb_adr_i == 4'h4) begin
      s2 <= wb_dat_i[7:0];
    end
  end
  // ****************************************
  // properties
  // ****************************************
  property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack1: assert property (p_ack1) else $error("ack longer than one cycle");
  property p_ackr; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ackr: assert property (p_ackr) else $error("request not answered");
  property p_src; ctl_o.active_src != 2'h3; endproperty
  a_src: assert property (p_src) else $error("reserved source active");
  property p_mult; ctl_o.fll_mult inside {11'h200, 11'h400, 11'h600, 11'h260, 11'h4C0, 11'h720};
  endproperty
  a_mult: assert property (p_mult) else $error("multiplier off table");
  property p_ctl2; calm |-> {ctl_o.bus_div, ctl_o.osc_band, ctl_o.osc_high_gain,
    ctl_o.osc_crystal} == {s2[7:4], s2[2]}; endproperty
  a_ctl2: assert property (p_ctl2) else $error("oscillator controls differ");
  property p_outs; calm |-> {ctl_o.int_ref_out, ctl_o.ext_ref_out} == {s1[1], s2[1]}; endproperty
  a_outs: assert property (p_outs) else $error("clock outputs differ");
  property p_stpi; stop_mode_i && sq == 2'h3 && !(s1[1] && s1[0]) |-> !ctl_o.int_ref_enable;
  endproperty
  a_stpi: assert property (p_stpi) else $error("internal ref runs in stop");
  property p_stpe; stop_mode_i && sq == 2'h3 && !(s2[1] && s2[0]) |-> !ctl_o.osc_enable;
  endproperty
  a_stpe: assert property (p_stpe) else $error("oscillator runs in stop");
  property p_lp; (s2[3] && !debug_mode_i && s1[7:6] inside {2'h1, 2'h2}
    && ctl_o.active_src != 2'h0)[*3] |-> !ctl_o.fll_enable; endproperty
  a_lp: assert property (p_lp) else $error("loop left on in bypass");
endmodule

bind fcs_clock_ctrl fcs_clock_ctrl_sva i_sva (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .debug_mode_i(debug_mode_i), .stop_mode_i(stop_mode_i), .ctl_o(ctl_o));

/* dv/fcs_clock_ctrl_test.sv */
// self-checking bench for the clock control block
`timescale 1ns/1ps
module fcs_clock_ctrl_test;
  import fcs_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, dbg = 1'b0, stop = 1'b0, avail = 1'b1;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        ready;
  fcs_ctl_s    ctl;
  int          errors = 0;
  int          cmp_count = 0;
  logic [7:0]  q;
  logic [10:0] mt [6] = '{11'h200, 11'h400, 11'h600, 11'h260, 11'h4C0, 11'h720};

  always #5 clk_i = ~clk_i;

  fcs_clock_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .debug_mode_i(dbg), .stop_mode_i(stop), .factory_trim_i(8'h5A),
    .factory_fine_trim_i(1'b1), .ext_ref_avail_i(avail), .osc_ready_i(ready), .ctl_o(ctl));
  fcs_osc_model i_osc (.clk_i(clk_i), .rst_i(rst_i), .osc_enable_i(ctl.osc_enable),
    .osc_ready_o(ready));

  // ****************************************
  // bus tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= s;
    dat <= {24'h0, d};
    // ack is read before this edge's updates land, i.e. the value sampled here
    // no cycle count assumed: only the watchdog ends a wait that never sees ack
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // the wait covers the slowest status path, a synchronised mode change
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(a, 1'b1, d, 4'hF);
    repeat (6) @(posedge clk_i);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(a, 1'b0, 8'h00, 4'hF);
    chk(q & m, e);
  endtask
  task automatic do_reset(input logic d);
    dbg   <= d;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    dbg   <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    do_reset(1'b0);
    rdc(4'h0, 8'hFF, 8'h04);
    rdc(4'h4, 8'hFF, 8'h40);
    rdc(4'h8, 8'hFF, 8'h5A);
    rdc(4'hC, 8'hFF, 8'h11);
    chk(ctl.trim, 8'h5A);
    chk(ctl.fine_trim, 1'b1);
    do_reset(1'b1);
    rdc(4'h8, 8'hFF, 8'h80);
    rdc(4'hC, 8'hFF, 8'h10);
    wr(4'h2, 8'hFF);
    rdc(4'h2, 8'hFF, 8'h00);
    bus(4'h0, 1'b1, 8'hC4, 4'hE);
    rdc(4'h0, 8'hFF, 8'h04);
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, {2'(i), 6'h04});
      rdc(4'h0, 8'hFF, {2'(i), 6'h04});
      rdc(4'hC, 8'h0C, (i == 3) ? 8'h00 : {4'h0, 2'(i), 2'h0});
      chk(ctl.active_src, (i == 3) ? 2'h0 : 2'(i));
    end
    wr(4'h0, 8'h44);
    avail <= 1'b0;
    wr(4'h0, 8'h84);
    rdc(4'hC, 8'h0C, 8'h04);
    avail <= 1'b1;
    wr(4'h0, 8'h28);
    rdc(4'hC, 8'h10, 8'h00);
    chk(ctl.fll_ref_int, 1'b0);
    chk({ctl.ref_div_hi, ctl.ref_div_log2}, 4'h5);
    wr(4'h0, 8'h04);
    for (int i = 0; i < 6; i++) begin
      wr(4'hC, {2'(i % 3), 1'(i / 3), 5'h00});
      rdc(4'hC, 8'hE0, {2'(i % 3), 1'(i / 3), 5'h00});
      chk(ctl.fll_mult, mt[i]);
    end
    wr(4'hC, 8'hFF);
    rdc(4'hC, 8'hFF, 8'hB1);
    wr(4'h4, 8'h48);
    wr(4'hC, 8'h00);
    chk({ctl.dco_band, ctl.fll_mult}, {2'h2, 11'h600});
    wr(4'h0, 8'h44);
    chk(ctl.fll_enable, 1'b0);
    dbg <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(ctl.fll_enable, 1'b1);
    dbg <= 1'b0;
    wr(4'h0, 8'h07);
    wr(4'h4, 8'hF3);
    chk({ctl.bus_div, ctl.osc_band, ctl.osc_high_gain}, 4'hF);
    chk({ctl.int_ref_out, ctl.ext_ref_out}, 2'h3);
    for (int k = 0; k < 2; k++) begin
      stop <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk({ctl.int_ref_enable, ctl.osc_enable}, (k == 0) ? 2'h3 : 2'h0);
      stop <= 1'b0;
      wr(4'h0, 8'h06);
      wr(4'h4, 8'hF2);
    end
    wr(4'h4, 8'h46);
    repeat (OSC_INIT_CYC + 100) @(posedge clk_i);
    rdc(4'hC, 8'h02, 8'h02);
    chk(ctl.osc_crystal, 1'b1);
    wr(4'h4, 8'h44);
    rdc(4'hC, 8'h02, 8'h00);
    tally_and_finish();
  end

  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
endmodule

/* dv/fcs_osc_model.sv */
// oscillator stand-in: reports running a set time after it is enabled
`timescale 1ns/1ps
module fcs_osc_model #(
  parameter int unsigned START = 16
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic osc_enable_i,
  output logic      osc_ready_o
);
  int unsigned cnt;
  // ready drops on the first clock edge after disable, with no count, the way a crystal stops swinging
  always_ff @(posedge clk_i) begin
    if (rst_i || !osc_enable_i) begin
      cnt         <= 0;
      osc_ready_o <= 1'b0;
    end else if (cnt < START) begin
      cnt <= cnt + 1;
    end else begin
      osc_ready_o <= 1'b1;
    end
  end
endmodule

/* src/fcs_clock_ctrl.sv */
// clock control block: registers, source selection, stop handling and status
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module fcs_clock_ctrl
  import fcs_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [3:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               debug_mode_i,
  input  wire logic               stop_mode_i,
  input  wire logic [7:0]         factory_trim_i,
  input  wire logic               factory_fine_trim_i,
  input  wire logic               ext_ref_avail_i,
  input  wire logic               osc_ready_i,
  output fcs_pkg::fcs_ctl_s       ctl_o
);
  import fcs_pkg::*;

  typedef struct packed {
    fcs_ctrl1_s             c1;
    fcs_ctrl2_s             c2;
    logic [7:0]             trim;
    logic                   fine_trim_bit;
    logic [1:0]             band_sel;
    logic                   dmx;
    logic                   trim_load;
    fcs_pwr_e               pwr;
    logic                   ir_armed;
    logic                   er_armed;
    logic [1:0]             src_req;
    logic [SYNC_STAGES-1:0][1:0] src_sync;
    logic [1:0]             src_act;
    logic [SYNC_STAGES-1:0] ref_sync;
    logic [SYNC_STAGES-1:0][1:0] band_sync;
    logic [11:0]            osc_cnt;
    logic                   osc_done;
    logic                   ack;
    logic [31:0]            rdat;
    fcs_ctl_s               ctl;
  } fcs_state_s;

  fcs_state_s st;
  fcs_state_s next_st;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [10:0] fll_mult(input logic [1:0] band, input logic dmx);
    logic [10:0] m;
    m = MULT_LO;
    case ({dmx, band})
      3'h0:    m = MULT_LO;
      3'h1:    m = MULT_MID;
      3'h2:    m = MULT_HI;
      3'h4:    m = MULT_LO_32;
      3'h5:    m = MULT_MID_32;
      3'h6:    m = MULT_HI_32;
      default: m = MULT_LO;
    endcase
    return m;
  endfunction

  function automatic logic [1:0] norm_src(input logic [1:0] code);
    return (code == CLK_RSVD) ? CLK_FLL : code;
  endfunction

  // only the external source can be missing; the others are always on chip
  function automatic logic ext_in_use_ok(input logic avail);
    return avail;
  endfunction

  logic        wr;
  logic        rd;
  logic        hit;
  logic [1:0]  src_new;
  logic [1:0]  mode_status;
  logic        ext_in_use;
  logic        bypassed;

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    next_st   = st;
    hit       = (wb_adr_i == OFS_CTRL_ONE) || (wb_adr_i == OFS_CTRL_TWO) ||
                (wb_adr_i == OFS_TRIM) || (wb_adr_i == OFS_STAT_CTRL);
    wr        = wb_cyc_i && wb_stb_i && !st.ack && wb_we_i && wb_sel_i[0] && hit;
    rd        = wb_cyc_i && wb_stb_i && !st.ack;
    src_new   = CLK_FLL;
    mode_status = st.src_act;
    ext_in_use  = 1'b0;
    bypassed    = 1'b0;

    // trim loads one cycle after reset release so ports are never sampled in reset
    next_st.trim_load = 1'b0;
    if (st.trim_load) begin
      next_st.trim  = debug_mode_i ? RST_TRIM_DBG : factory_trim_i;
      next_st.fine_trim_bit = debug_mode_i ? RST_FINE_TRIM_BIT_DBG : factory_fine_trim_i;
    end

    // bus slave: ack one cycle after the request, dropped the cycle after
    next_st.ack = rd;
    if (wr) begin
      case (wb_adr_i)
        OFS_CTRL_ONE: next_st.c1 = wb_dat_i[7:0];
        OFS_CTRL_TWO: next_st.c2 = wb_dat_i[7:0];
        OFS_TRIM:     next_st.trim = wb_dat_i[7:0];
        OFS_STAT_CTRL: begin
          next_st.fine_trim_bit = wb_dat_i[POS_FINE_TRIM_BIT];
          next_st.dmx   = wb_dat_i[POS_DMX];
          // discarded when reserved or under low power
          if (wb_dat_i[POS_DCOBAND +: 2] != BAND_RSVD && !st.c2.fll_low_power) begin
            next_st.band_sel = wb_dat_i[POS_DCOBAND +: 2];
          end
        end
        default: ;
      endcase
    end

    // source request: an unavailable external source keeps the old clock
    src_new = norm_src(st.c1.clk_sel);
    if (src_new == CLK_EXT && !ext_in_use_ok(ext_ref_avail_i)) begin
      src_new = st.src_req;
    end
    next_st.src_req = src_new;

    // status synchronisers toward the clock tree and back
    next_st.src_sync  = {st.src_sync[SYNC_STAGES-2:0], st.src_req};
    next_st.src_act   = st.src_sync[SYNC_STAGES-1];
    next_st.ref_sync  = {st.ref_sync[SYNC_STAGES-2:0], st.c1.int_ref_sel};
    next_st.band_sync = {st.band_sync[SYNC_STAGES-2:0], st.band_sel};

    // stop: keep flags captured on entry
    case (st.pwr)
      ST_RUN: begin
        next_st.ir_armed = st.c1.int_ref_out_en;
        next_st.er_armed = st.c2.ext_ref_out_en;
        if (stop_mode_i) begin
          next_st.pwr = ST_STOP;
        end
      end
      ST_STOP: begin
        if (!stop_mode_i) begin
          next_st.pwr = ST_RUN;
        end
      end
      default: next_st.pwr = ST_RUN;
    endcase

    // oscillator initialisation
    ext_in_use = st.c2.ext_ref_out_en || !st.ref_sync[SYNC_STAGES-1] ||
                 (st.src_act == CLK_EXT);
    if (!st.c2.ext_ref_out_en || !st.c2.ext_src_sel) begin
      next_st.osc_cnt  = 12'h000;
      next_st.osc_done = 1'b0;
    end else if (ext_in_use && osc_ready_i && !st.osc_done) begin
      if (st.osc_cnt == OSC_INIT_CNT) begin
        next_st.osc_done = 1'b1;
      end else begin
        next_st.osc_cnt = st.osc_cnt + 12'h001;
      end
    end

    // outputs to the clock tree
    bypassed = (st.src_act != CLK_FLL);
    next_st.ctl.active_src     = st.src_act;
    next_st.ctl.ref_div_log2   = st.c1.ref_div;
    next_st.ctl.ref_div_hi     = st.c2.osc_band;
    next_st.ctl.fll_ref_int    = st.c1.int_ref_sel;
    next_st.ctl.fll_enable     = (st.pwr == ST_RUN) &&
                                 !(bypassed && st.c2.fll_low_power && !debug_mode_i);
    next_st.ctl.bus_div        = st.c2.bus_div;
    next_st.ctl.osc_band       = st.c2.osc_band;
    next_st.ctl.osc_high_gain  = st.c2.osc_high_gain;
    next_st.ctl.osc_crystal    = st.c2.ext_src_sel;
    if (st.pwr == ST_STOP) begin
      next_st.ctl.int_ref_enable = st.c1.int_ref_stop_keep && st.ir_armed;
      next_st.ctl.osc_enable     = st.c2.ext_ref_stop_keep && st.er_armed;
      next_st.ctl.int_ref_out    = st.c1.int_ref_stop_keep && st.ir_armed && st.c1.int_ref_out_en;
      next_st.ctl.ext_ref_out    = st.c2.ext_ref_stop_keep && st.er_armed && st.c2.ext_ref_out_en;
    end else begin
      next_st.ctl.int_ref_enable = 1'b1;
      next_st.ctl.osc_enable     = ext_in_use;
      next_st.ctl.int_ref_out    = st.c1.int_ref_out_en;
      next_st.ctl.ext_ref_out    = st.c2.ext_ref_out_en;
    end
    next_st.ctl.trim           = st.trim;
    next_st.ctl.fine_trim      = st.fine_trim_bit;
    next_st.ctl.dco_band       = st.band_sync[SYNC_STAGES-1];
    next_st.ctl.fll_mult       = fll_mult(st.band_sync[SYNC_STAGES-1], st.dmx);

    // read data, unmapped addresses read zero
    next_st.rdat = 32'h0000_0000;
    if (rd) begin
      case (wb_adr_i)
        OFS_CTRL_ONE: next_st.rdat[7:0] = st.c1;
        OFS_CTRL_TWO: next_st.rdat[7:0] = st.c2;
        OFS_TRIM:     next_st.rdat[7:0] = st.trim;
        OFS_STAT_CTRL: begin
          next_st.rdat[POS_DCOBAND +: 2] = st.band_sync[SYNC_STAGES-1];
          next_st.rdat[POS_DMX]          = st.dmx;
          next_st.rdat[POS_REFST]        = st.ref_sync[SYNC_STAGES-1];
          next_st.rdat[POS_MODEST +: 2]  = mode_status;
          next_st.rdat[POS_OSCDONE]      = st.osc_done;
          next_st.rdat[POS_FINE_TRIM_BIT]        = st.fine_trim_bit;
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st                      <= '0;
      st.c1.clk_sel           <= RST_CLKSEL;
      st.c1.ref_div           <= RST_REFDIV;
      st.c1.int_ref_sel       <= RST_IREFSEL;
      st.c2.bus_div           <= RST_BUSDIV;
      st.trim                 <= RST_TRIM_DBG;
      st.band_sel             <= RST_DCOBAND;
      st.trim_load            <= 1'b1;
      st.pwr                  <= ST_RUN;
      st.ref_sync             <= '1;
      st.ctl.fll_ref_int      <= RST_IREFSEL;
      st.ctl.bus_div          <= RST_BUSDIV;
      st.ctl.int_ref_enable   <= 1'b1;
      st.ctl.fll_enable       <= 1'b1;
      st.ctl.trim             <= RST_TRIM_DBG;
      st.ctl.fll_mult         <= MULT_LO;
    end else begin
      st <= next_st;
    end
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdat;
  assign ctl_o    = st.ctl;

endmodule

/* src/fcs_pkg.sv */
// package: register map, field layout, reset values and timing for the clock control block
package fcs_pkg;

  // ****************************************
  // register map (byte addresses, one word each)
  // ****************************************
  localparam logic [3:0] OFS_CTRL_ONE  = 4'h0;
  localparam logic [3:0] OFS_CTRL_TWO  = 4'h4;
  localparam logic [3:0] OFS_TRIM      = 4'h8;
  localparam logic [3:0] OFS_STAT_CTRL = 4'hC;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned POS_CLKSEL   = 6;
  localparam int unsigned POS_REFDIV   = 3;
  localparam int unsigned POS_IREFSEL  = 2;
  localparam int unsigned POS_IROUTEN  = 1;
  localparam int unsigned POS_IRSTOP   = 0;
  localparam int unsigned POS_BUSDIV   = 6;
  localparam int unsigned POS_BAND     = 5;
  localparam int unsigned POS_HGAIN    = 4;
  localparam int unsigned POS_LOWPWR   = 3;
  localparam int unsigned POS_EXTSRC   = 2;
  localparam int unsigned POS_EROUTEN  = 1;
  localparam int unsigned POS_ERSTOP   = 0;
  localparam int unsigned POS_DCOBAND  = 6;
  localparam int unsigned POS_DMX      = 5;
  localparam int unsigned POS_REFST    = 4;
  localparam int unsigned POS_MODEST   = 2;
  localparam int unsigned POS_OSCDONE  = 1;
  localparam int unsigned POS_FINE_TRIM_BIT    = 0;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [1:0] RST_CLKSEL    = 2'h0;
  localparam logic [2:0] RST_REFDIV    = 3'h0;
  localparam logic       RST_IREFSEL   = 1'h1;
  localparam logic [1:0] RST_BUSDIV    = 2'h1;
  localparam logic [7:0] RST_TRIM_DBG  = 8'h80;
  localparam logic       RST_FINE_TRIM_BIT_DBG = 1'h0;
  localparam logic [1:0] RST_DCOBAND   = 2'h0;

  // ****************************************
  // codes and timing
  // ****************************************
  localparam logic [1:0] CLK_FLL     = 2'h0;
  localparam logic [1:0] CLK_INT     = 2'h1;
  localparam logic [1:0] CLK_EXT     = 2'h2;
  localparam logic [1:0] CLK_RSVD    = 2'h3;
  localparam logic [1:0] BAND_RSVD   = 2'h3;
  localparam logic [2:0] REFDIV_HI_MAX = 3'h5;
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned OSC_INIT_US = 40;
  localparam int unsigned OSC_INIT_CYC = OSC_INIT_US * CLK_MHZ;
  localparam logic [11:0] OSC_INIT_CNT = 12'(OSC_INIT_CYC);

  // multiplier table, indexed by {dmx, band}
  localparam logic [10:0] MULT_LO     = 11'h200;
  localparam logic [10:0] MULT_MID    = 11'h400;
  localparam logic [10:0] MULT_HI     = 11'h600;
  localparam logic [10:0] MULT_LO_32  = 11'h260;
  localparam logic [10:0] MULT_MID_32 = 11'h4C0;
  localparam logic [10:0] MULT_HI_32  = 11'h720;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_STOP
  } fcs_pwr_e;

  typedef struct packed {
    logic [1:0] clk_sel;
    logic [2:0] ref_div;
    logic       int_ref_sel;
    logic       int_ref_out_en;
    logic       int_ref_stop_keep;
  } fcs_ctrl1_s;

  typedef struct packed {
    logic [1:0] bus_div;
    logic       osc_band;
    logic       osc_high_gain;
    logic       fll_low_power;
    logic       ext_src_sel;
    logic       ext_ref_out_en;
    logic       ext_ref_stop_keep;
  } fcs_ctrl2_s;

  // oscillator and clock tree controls handed to the analog side
  typedef struct packed {
    logic [1:0]  active_src;
    logic [2:0]  ref_div_log2;
    logic        ref_div_hi;
    logic        fll_ref_int;
    logic        fll_enable;
    logic [1:0]  bus_div;
    logic        osc_band;
    logic        osc_high_gain;
    logic        osc_crystal;
    logic        osc_enable;
    logic        int_ref_out;
    logic        ext_ref_out;
    logic        int_ref_enable;
    logic [7:0]  trim;
    logic        fine_trim;
    logic [1:0]  dco_band;
    logic [10:0] fll_mult;
  } fcs_ctl_s;

endpackage
